/* design/lfosc_pkg.sv */
// Package for the low-frequency oscillator control block.
// Assumes a single 250 MHz clock domain and an Avalon-MM register slave.
package lfosc_pkg;

  // Register byte addresses (word aligned except LFOSC_CTRL_IDX, 32-bit data)
  localparam logic [7:0] LFOSC_CTRL_OFS = 8'hE0;
  localparam logic [7:0] LFOSC_EXT_OFS = 8'hE4;
  localparam logic [7:0] LFOSC_TCTL_OFS = 8'hE8;
  localparam logic [7:0] LFOSC_T2CNT_OFS = 8'hEC;
  localparam logic [7:0] LFOSC_T2RLD_OFS = 8'hF0;
  localparam logic [7:0] LFOSC_T3CNT_OFS = 8'hF4;
  localparam logic [7:0] LFOSC_T3RLD_OFS = 8'hF8;
  localparam logic [7:0] LFOSC_IRQ_STAT_OFS = 8'hC0;
  localparam logic [7:0] LFOSC_IRQ_CLR_OFS = 8'hC4;
  localparam logic [7:0] LFOSC_IRQ_EN_OFS = 8'hC8;
  localparam logic [7:0] LFOSC_CTRL_IDX = 8'hE3;

  // Control register fields
  localparam int LFOSC_EN_BIT = 7;
  localparam int LFOSC_RDY_BIT = 6;
  localparam int LFOSC_TUNE_LSB = 2;
  localparam int LFOSC_TUNE_W = 4;
  localparam int LFOSC_DIV_LSB = 0;
  localparam int LFOSC_DIV_W = 2;
  localparam logic [3:0] LFOSC_TUNE_RST = 4'h8;
  localparam logic [1:0] LFOSC_DIV_RST = 2'h0;

  // External oscillator control fields
  localparam int LFOSC_XVLD_BIT = 7;
  localparam int LFOSC_XMODE_LSB = 4;
  localparam int LFOSC_XFR_LSB = 0;

  // Timer control: bit0 timer2 capture mode, bit1 timer3 capture mode,
  // bit2 timer2 run, bit3 timer3 run
  localparam int LFOSC_T2CAP_BIT = 0;
  localparam int LFOSC_T3CAP_BIT = 1;
  localparam int LFOSC_T2RUN_BIT = 2;
  localparam int LFOSC_T3RUN_BIT = 3;

  // Interrupt status bits
  localparam int LFOSC_IRQ_RDY = 0;
  localparam int LFOSC_IRQ_T2CAP = 1;
  localparam int LFOSC_IRQ_T3CAP = 2;
  localparam int LFOSC_IRQ_W = 3;

  // Oscillator nominal frequency and settle time
  localparam int LFOSC_NOM_KHZ = 80;
  localparam int LFOSC_CLK_MHZ = 250;
  localparam int LFOSC_HALF_CYC = (LFOSC_CLK_MHZ * 1000)
                                  / (2 * LFOSC_NOM_KHZ);
  localparam int LFOSC_SETTLE_US = 100;
  localparam int LFOSC_SETTLE_CYC = LFOSC_SETTLE_US * LFOSC_CLK_MHZ;

  // External oscillator modes
  localparam logic [2:0] LFOSC_XM_CMOS = 3'h2;
  localparam logic [2:0] LFOSC_XM_CMOS2 = 3'h3;
  localparam logic [2:0] LFOSC_XM_RC = 3'h4;
  localparam logic [2:0] LFOSC_XM_CAP = 3'h5;
  localparam logic [2:0] LFOSC_XM_XTAL = 3'h6;
  localparam logic [2:0] LFOSC_XM_CRYSTAL_OUT_PIN = 3'h7;

  typedef enum logic [1:0] {
    LFOSC_ST_OFF,
    LFOSC_ST_SETTLE,
    LFOSC_ST_RUN
  } lfosc_state_e;

endpackage : lfosc_pkg

/* design/lfosc_div.sv */
// Glitch-free selectable divider for the low-frequency oscillator tick.
// Assumes i_tick pulses once per raw oscillator half period.
`timescale 1ns/100ps
module lfosc_div
  import lfosc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_tick,
  input wire logic [1:0] i_sel,
  output logic o_clk
);

  logic [2:0] cnt;
  logic [1:0] sel_act;
  logic out_q;
  logic [2:0] half_lim;
  logic wrap;

  // Code 00 is /8, 01 /4, 10 /2, 11 /1 (half periods in raw ticks)
  assign half_lim = (sel_act == 2'h0) ? 3'h7 :
                    (sel_act == 2'h1) ? 3'h3 :
                    (sel_act == 2'h2) ? 3'h1 : 3'h0;
  assign wrap = i_tick && (cnt >= half_lim);
  assign o_clk = out_q;

  // Ratio switches only when the output falls, so no runt pulse
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      cnt <= 3'h0;
      sel_act <= LFOSC_DIV_RST;
      out_q <= 1'b0;
    end else if (wrap) begin
      cnt <= 3'h0;
      out_q <= ~out_q;
      if (out_q) begin
        sel_act <= i_sel;
      end
    end else if (i_tick) begin
      cnt <= cnt + 3'h1;
    end
  end

endmodule : lfosc_div

/* design/lfosc_top.sv */
// Low-frequency oscillator control, capture timers and external
// oscillator pin assignment. Assumes an Avalon-MM master on i_ref_clk and
// an external oscillator pad whose valid flag arrives asynchronously.
`timescale 1ns/100ps
// Function
// - Internal 80 kHz oscillator divided by one, two, four or eight.
// - Divider code 00 /8, 01 /4, 10 /2, 11 /1.
// - Control bit 7 enables the oscillator; read/write, resets zero.
// - Read-only bit 6 is one once the oscillator has stabilized.
// - Ready clears only on reset or a write changing the divider code.
// - Bits 5..2 fine-tune: 0000 fastest, 1111 slowest.
// - Timer two captures on falling, timer three on rising output edges.
// - A capture copies the timer count into its reload register.
// - Crystal mode uses P0.2 as crystal input and P0.3 as output.
// - Capacitor, RC or CMOS mode uses only P0.3 as crystal output.
module lfosc_top
  import lfosc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  input wire logic i_crystal_valid,
  output logic o_lf_clk,
  output logic [3:0] o_lf_osc_fine_tune,
  output logic o_crystal_in_pin_en,
  output logic o_crystal_out_pin_en,
  output logic o_irq
);

  // Control register state
  logic lf_osc_enable;
  logic lf_osc_ready_flag;
  logic [3:0] lf_osc_fine_tune;
  logic [1:0] lf_osc_divider_select;
  logic [2:0] ext_osc_mode;
  logic [2:0] ext_osc_freq_range;
  logic [3:0] tmr_ctrl;
  logic [15:0] t2_count_value;
  logic [15:0] t2_reload_value;
  logic [15:0] t3_count_value;
  logic [15:0] t3_reload_value;
  logic [LFOSC_IRQ_W-1:0] irq_stat;
  logic [LFOSC_IRQ_W-1:0] irq_en;

  // Bus answer registers
  logic ack;
  logic [31:0] rdata;
  logic [1:0] resp;

  // Oscillator model
  lfosc_state_e state;
  logic [15:0] settle_cnt;
  logic [10:0] half_cnt;
  logic raw_tick;
  logic [10:0] half_lim;

  // Crystal valid synchroniser
  logic xv_s1;
  logic xv_s2;
  logic xv_s3;
  logic xv_stable;

  // Divided clock edge detect
  logic lf_clk;
  logic lf_clk_q;
  logic lf_rise;
  logic lf_fall;

  // Bus decode
  wire req = i_avs_read | i_avs_write;
  wire take = req & ~ack;
  wire wr = take & i_avs_write;
  wire lane0 = i_avs_byteenable[0];
  wire lane1 = i_avs_byteenable[1];
  wire [7:0] wd0 = i_avs_writedata[7:0];
  wire [15:0] wd16 = i_avs_writedata[15:0];
  wire hit_ctrl = (i_avs_address == LFOSC_CTRL_OFS);
  wire hit_ext = (i_avs_address == LFOSC_EXT_OFS);
  wire hit_tctl = (i_avs_address == LFOSC_TCTL_OFS);
  wire hit_t2c = (i_avs_address == LFOSC_T2CNT_OFS);
  wire hit_t2r = (i_avs_address == LFOSC_T2RLD_OFS);
  wire hit_t3c = (i_avs_address == LFOSC_T3CNT_OFS);
  wire hit_t3r = (i_avs_address == LFOSC_T3RLD_OFS);
  wire hit_ist = (i_avs_address == LFOSC_IRQ_STAT_OFS);
  wire hit_icl = (i_avs_address == LFOSC_IRQ_CLR_OFS);
  wire hit_ien = (i_avs_address == LFOSC_IRQ_EN_OFS);
  wire hit_any = hit_ctrl | hit_ext | hit_tctl | hit_t2c | hit_t2r |
                 hit_t3c | hit_t3r | hit_ist | hit_icl | hit_ien;
  wire wr_ctrl = wr & hit_ctrl & lane0;
  wire div_change = wr_ctrl &
       (wd0[LFOSC_DIV_LSB +: LFOSC_DIV_W] != lf_osc_divider_select);
  wire wr_en16 = lane0 & lane1;

  wire [7:0] ctrl_byte = {lf_osc_enable, lf_osc_ready_flag,
                          lf_osc_fine_tune, lf_osc_divider_select};
  wire xtal_mode = (ext_osc_mode == LFOSC_XM_XTAL) ||
                   (ext_osc_mode == LFOSC_XM_CRYSTAL_OUT_PIN);
  wire xv_valid_rd = xtal_mode & xv_stable;
  wire [7:0] ext_byte = {xv_valid_rd, ext_osc_mode, 1'b0,
                         ext_osc_freq_range};
  wire one_pin_mode = (ext_osc_mode == LFOSC_XM_CMOS) ||
                      (ext_osc_mode == LFOSC_XM_CMOS2) ||
                      (ext_osc_mode == LFOSC_XM_RC) ||
                      (ext_osc_mode == LFOSC_XM_CAP);

  wire [31:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl_byte} :
    hit_ext ? {24'h000000, ext_byte} :
    hit_tctl ? {28'h0000000, tmr_ctrl} :
    hit_t2c ? {16'h0000, t2_count_value} :
    hit_t2r ? {16'h0000, t2_reload_value} :
    hit_t3c ? {16'h0000, t3_count_value} :
    hit_t3r ? {16'h0000, t3_reload_value} :
    hit_ist ? {29'h0, irq_stat} :
    hit_ien ? {29'h0, irq_en} : 32'h00000000;

  // Captures fire on the divided output edges
  wire t2_cap = tmr_ctrl[LFOSC_T2CAP_BIT] & lf_fall;
  wire t3_cap = tmr_ctrl[LFOSC_T3CAP_BIT] & lf_rise;
  wire rdy_set = (state == LFOSC_ST_SETTLE) && !div_change &&
                 (settle_cnt == 16'(LFOSC_SETTLE_CYC - 1));
  wire [LFOSC_IRQ_W-1:0] irq_evt = {t3_cap, t2_cap, rdy_set};
  wire [LFOSC_IRQ_W-1:0] irq_clr = (wr & hit_icl & lane0) ?
                                   wd0[LFOSC_IRQ_W-1:0] : '0;

  // Slower fine-tune codes stretch the half period
  assign half_lim = 11'(LFOSC_HALF_CYC) + {3'h0, lf_osc_fine_tune, 4'h0}
                    - 11'h080;
  // At or past the limit, so a faster tune code never waits for a wrap
  assign raw_tick = (state != LFOSC_ST_OFF) && (half_cnt >= half_lim);

  assign o_avs_waitrequest = req & ~ack;
  assign o_avs_readdata = rdata;
  assign o_avs_response = resp;
  assign o_lf_clk = lf_clk;
  assign o_lf_osc_fine_tune = lf_osc_fine_tune;
  assign o_irq = |(irq_stat & irq_en);
  // Pin claims per external oscillator mode
  assign o_crystal_in_pin_en = xtal_mode;
  assign o_crystal_out_pin_en = xtal_mode | one_pin_mode;

  // Divider to the output ratio
  lfosc_div u_div (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_tick(raw_tick),
    .i_sel(lf_osc_divider_select),
    .o_clk(lf_clk)
  );

  // Bus answer: one wait cycle, then acknowledge
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
      resp <= 2'h0;
    end else begin
      ack <= take;
      if (take) begin
        rdata <= i_avs_read ? rd_mux : 32'h00000000;
        resp <= hit_any ? 2'h0 : 2'h3;
      end
    end
  end

  // Control register fields
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      lf_osc_enable <= 1'b0;
      lf_osc_fine_tune <= LFOSC_TUNE_RST;
      lf_osc_divider_select <= LFOSC_DIV_RST;
    end else if (wr_ctrl) begin
      lf_osc_enable <= wd0[LFOSC_EN_BIT];
      lf_osc_fine_tune <= wd0[LFOSC_TUNE_LSB +: LFOSC_TUNE_W];
      lf_osc_divider_select <= wd0[LFOSC_DIV_LSB +: LFOSC_DIV_W];
    end
  end

  // Ready is sticky until reset or a divider change
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      lf_osc_ready_flag <= 1'b0;
    end else if (div_change) begin
      lf_osc_ready_flag <= 1'b0;
    end else if (rdy_set) begin
      lf_osc_ready_flag <= 1'b1;
    end
  end

  // Oscillator run and settle sequence; a divider change resettles
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state <= LFOSC_ST_OFF;
      settle_cnt <= 16'h0000;
    end else begin
      case (state)
        LFOSC_ST_OFF: begin
          settle_cnt <= 16'h0000;
          if (lf_osc_enable) begin
            state <= LFOSC_ST_SETTLE;
          end
        end
        LFOSC_ST_SETTLE: begin
          settle_cnt <= settle_cnt + 16'h0001;
          if (!lf_osc_enable) begin
            state <= LFOSC_ST_OFF;
          end else if (div_change) begin
            // A new ratio mid-settle restarts the wait so ready stays honest
            settle_cnt <= 16'h0000;
          end else if (rdy_set) begin
            state <= LFOSC_ST_RUN;
          end
        end
        LFOSC_ST_RUN: begin
          if (!lf_osc_enable) begin
            state <= LFOSC_ST_OFF;
          end else if (div_change) begin
            settle_cnt <= 16'h0000;
            state <= LFOSC_ST_SETTLE;
          end
        end
        default: begin
          state <= LFOSC_ST_OFF;
        end
      endcase
    end
  end

  // Raw half-period counter
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      half_cnt <= 11'h000;
    end else if (raw_tick || state == LFOSC_ST_OFF) begin
      half_cnt <= 11'h000;
    end else begin
      half_cnt <= half_cnt + 11'h001;
    end
  end

  // External oscillator, timer control and interrupt enable registers; software owns mode and range
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ext_osc_mode <= 3'h0;
      ext_osc_freq_range <= 3'h0;
      tmr_ctrl <= 4'h0;
      irq_en <= '0;
    end else begin
      if (wr & hit_ext & lane0) begin
        ext_osc_mode <= wd0[LFOSC_XMODE_LSB +: 3];
        ext_osc_freq_range <= wd0[LFOSC_XFR_LSB +: 3];
      end
      if (wr & hit_tctl & lane0) begin
        tmr_ctrl <= wd0[3:0];
      end
      if (wr & hit_ien & lane0) begin
        irq_en <= wd0[LFOSC_IRQ_W-1:0];
      end
    end
  end

  // Crystal valid flag: change accepted once stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      xv_s1 <= 1'b0;
      xv_s2 <= 1'b0;
      xv_s3 <= 1'b0;
      xv_stable <= 1'b0;
    end else begin
      xv_s1 <= i_crystal_valid;
      xv_s2 <= xv_s1;
      xv_s3 <= xv_s2;
      if (xv_s2 == xv_s3) begin
        xv_stable <= xv_s3;
      end
    end
  end

  // Edge detect on the divided clock, same domain
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      lf_clk_q <= 1'b0;
    end else begin
      lf_clk_q <= lf_clk;
    end
  end
  assign lf_rise = lf_clk & ~lf_clk_q;
  assign lf_fall = ~lf_clk & lf_clk_q;

  // Timers count the reference clock; captures copy into reload
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      t2_count_value <= 16'h0000;
      t3_count_value <= 16'h0000;
      t2_reload_value <= 16'h0000;
      t3_reload_value <= 16'h0000;
    end else begin
      if (wr & hit_t2c & wr_en16) begin
        t2_count_value <= wd16;
      end else if (tmr_ctrl[LFOSC_T2RUN_BIT]) begin
        t2_count_value <= t2_count_value + 16'h0001;
      end
      if (wr & hit_t3c & wr_en16) begin
        t3_count_value <= wd16;
      end else if (tmr_ctrl[LFOSC_T3RUN_BIT]) begin
        t3_count_value <= t3_count_value + 16'h0001;
      end
      if (t2_cap) begin
        t2_reload_value <= t2_count_value;
      end else if (wr & hit_t2r & wr_en16) begin
        t2_reload_value <= wd16;
      end
      if (t3_cap) begin
        t3_reload_value <= t3_count_value;
      end else if (wr & hit_t3r & wr_en16) begin
        t3_reload_value <= wd16;
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
    end
  end

endmodule : lfosc_top

/* dv/lfosc_top_assertions.sv */
// Checker for lfosc_top, watching only its top-level ports.
// Assumes the Avalon master holds each request until waitrequest is low.
`timescale 1ns/100ps
module lfosc_chk
  import lfosc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire logic [1:0] o_avs_response,
  input wire logic o_lf_clk,
  input wire logic [3:0] o_lf_osc_fine_tune,
  input wire logic o_crystal_in_pin_en,
  input wire logic o_crystal_out_pin_en,
  input wire logic o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire req = i_avs_read || i_avs_write;
  wire ack = req && !o_avs_waitrequest;
  wire wack = i_avs_write && ack && i_avs_byteenable[0];
  wire mapped = i_avs_address inside {LFOSC_CTRL_OFS, LFOSC_EXT_OFS,
    LFOSC_TCTL_OFS, LFOSC_T2CNT_OFS, LFOSC_T2RLD_OFS, LFOSC_T3CNT_OFS,
    LFOSC_T3RLD_OFS, LFOSC_IRQ_STAT_OFS, LFOSC_IRQ_CLR_OFS,
    LFOSC_IRQ_EN_OFS};

  a_wait_one: assert property
    ($rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("waitrequest not exactly one cycle");
  a_wait_idle: assert property (!req |-> !o_avs_waitrequest)
    else $error("waitrequest without request");
  a_bad_addr: assert property
    (i_avs_read && ack && !mapped |-> o_avs_response == 2'h3)
    else $error("unmapped read not refused");
  a_good_addr: assert property
    (i_avs_read && ack && mapped |-> o_avs_response == 2'h0)
    else $error("mapped read refused");
  a_pin_nest: assert property
    (o_crystal_in_pin_en |-> o_crystal_out_pin_en)
    else $error("crystal input claimed without output");
  a_pin_mode: assert property
    (wack && i_avs_address == LFOSC_EXT_OFS |-> ##2
     o_crystal_in_pin_en == ($past(i_avs_writedata[6:5], 2) == 2'h3) &&
     o_crystal_out_pin_en == ($past(i_avs_writedata[6:4], 2) >= 3'h2))
    else $error("pin claim does not follow mode");
  a_tune_port: assert property
    (wack && i_avs_address == LFOSC_CTRL_OFS |-> ##2
     o_lf_osc_fine_tune == $past(i_avs_writedata[5:2], 2))
    else $error("fine tune port not updated");
  a_irq_mask: assert property
    (wack && i_avs_address == LFOSC_IRQ_EN_OFS &&
     i_avs_writedata[2:0] == 3'h0 |-> ##2 !o_irq)
    else $error("masked interrupt still raised");
  a_clk_high: assert property
    ($rose(o_lf_clk) |=> o_lf_clk [*8])
    else $error("runt high pulse on divided clock");
  a_clk_low: assert property
    ($fell(o_lf_clk) |=> !o_lf_clk [*8])
    else $error("runt low pulse on divided clock");

  c_bad_addr: cover property (i_avs_read && ack && !mapped);
  c_irq: cover property ($rose(o_irq));
  c_xtal: cover property ($rose(o_crystal_in_pin_en));
endmodule : lfosc_chk

bind lfosc_top lfosc_chk i_chk (.i_ref_clk, .i_resetn, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
  .o_avs_waitrequest, .o_avs_response, .o_lf_clk, .o_lf_osc_fine_tune,
  .o_crystal_in_pin_en, .o_crystal_out_pin_en, .o_irq);

/* dv/lfosc_xtal_model.sv */
// Crystal source model: reports stable only after a settling delay.
// Assumes the crystal is driven only while its input pin is claimed.
`timescale 1ns/100ps
module lfosc_xtal_model #(
  parameter int SETTLE = 200
) (
  input wire logic i_ref_clk,
  input wire logic i_drive,
  output logic o_valid
);
  int cnt = 0;
  initial o_valid = 1'b0;
  // Amplitude is lost at once when the drive stops
  always @(posedge i_ref_clk) begin
    cnt <= i_drive ? cnt + 1 : 0;
    o_valid <= i_drive && cnt >= SETTLE;
  end
endmodule : lfosc_xtal_model

/* dv/lfosc_top_bench.sv */
// Self-checking bench for lfosc_top: registers, divider, capture, pins.
// Assumes the crystal model on the valid input; the checker is bound.
`timescale 1ns/100ps
module lfosc_top_bench
  import lfosc_pkg::*;
;
  localparam int XS = 200; // Far below 1 ms so runs stay short
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_lf_clk, o_irq, i_crystal_valid;
  logic o_crystal_in_pin_en, o_crystal_out_pin_en;
  logic [1:0] o_avs_response;
  logic [3:0] o_lf_osc_fine_tune;
  logic [31:0] qd[$], qm[$];
  logic [1:0] qr[$];
  logic [16:0] seed = 17'h124AB;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  lfosc_top i_dut (.i_ref_clk, .i_resetn, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .o_avs_response, .i_crystal_valid, .o_lf_clk,
    .o_lf_osc_fine_tune, .o_crystal_in_pin_en, .o_crystal_out_pin_en,
    .o_irq);
  lfosc_xtal_model #(.SETTLE(XS)) i_xtal (.i_ref_clk,
    .i_drive(o_crystal_in_pin_en), .o_valid(i_crystal_valid));

  initial forever #2 i_ref_clk = ~i_ref_clk;

  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction : lfsr

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  // Waitrequest and read data are taken at the edge that ends the wait
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge i_ref_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do @(posedge i_ref_clk); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input logic [1:0] r, output logic [31:0] q);
    qd.push_back(e & m);
    qm.push_back(m);
    qr.push_back(r);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic per(output int p);
    int t;
    @(posedge o_lf_clk);
    t = cyc;
    @(posedge o_lf_clk);
    p = cyc - t;
  endtask : per

  always @(negedge i_ref_clk) begin
    if (i_avs_read && o_avs_waitrequest === 1'b0 && qd.size() > 0) begin
      chk("read data", o_avs_readdata & qm[0], qd[0]);
      chk("response", 32'(o_avs_response), 32'(qr[0]));
      void'(qd.pop_front());
      void'(qm.pop_front());
      void'(qr.pop_front());
    end
  end

  // Counted on the falling edge so period reads never race the count
  always @(negedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    int pf, ps, p2;
    logic [31:0] q, e;
    logic [15:0] r[3];
    repeat (4) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    chk("tune port", 32'(o_lf_osc_fine_tune), 32'(LFOSC_TUNE_RST));
    rd(LFOSC_CTRL_OFS, 32'h20, 32'hFF, 2'h0, q);
    rd(LFOSC_EXT_OFS, 32'h0, 32'hFF, 2'h0, q);
    rd(8'h10, 32'h0, 32'hFFFFFFFF, 2'h3, q);
    $display("test reset done");
    wr(LFOSC_IRQ_EN_OFS, 32'h1);
    wr(LFOSC_TCTL_OFS, 32'hF);
    wr(LFOSC_CTRL_OFS, 32'hA3);
    rd(LFOSC_CTRL_OFS, 32'hA3, 32'hFF, 2'h0, q);
    wait (o_irq === 1'b1);
    rd(LFOSC_CTRL_OFS, 32'hE3, 32'hFF, 2'h0, q);
    foreach (r[i]) begin
      @(negedge o_lf_clk);
      repeat (8) @(posedge i_ref_clk);
      rd(LFOSC_T2RLD_OFS, 32'h0, 32'h0, 2'h0, q);
      r[i] = q[15:0];
    end
    chk("capture step", 32'(16'(r[1] - r[0])),
        32'(16'(r[2] - r[1])));
    chk("capture moved", 32'(r[1] != r[0]), 32'h1);
    rd(LFOSC_IRQ_STAT_OFS, 32'h6, 32'h6, 2'h0, q);
    $display("test capture done");
    wr(LFOSC_CTRL_OFS, 32'h83);
    per(pf);
    wr(LFOSC_CTRL_OFS, 32'hBF);
    per(ps);
    chk("tune order", 32'(ps > pf), 32'h1);
    rd(LFOSC_CTRL_OFS, 32'hFF, 32'hFF, 2'h0, q);
    wr(LFOSC_CTRL_OFS, 32'hBE);
    rd(LFOSC_CTRL_OFS, 32'hBE, 32'hFF, 2'h0, q);
    wr(LFOSC_IRQ_CLR_OFS, 32'h7);
    rd(LFOSC_IRQ_STAT_OFS, 32'h0, 32'h1, 2'h0, q);
    chk("irq cleared", 32'(o_irq), 32'h0);
    wait (o_irq === 1'b1);
    per(p2);
    chk("divide ratio", p2, 2 * ps);
    wr(LFOSC_IRQ_EN_OFS, 32'h0);
    repeat (2) @(posedge i_ref_clk);
    chk("irq masked", 32'(o_irq), 32'h0);
    for (int d = 0; d < 4; d++) begin
      wr(LFOSC_CTRL_OFS, 32'h80 | d);
      rd(LFOSC_CTRL_OFS, 32'h80 | d, 32'hFF, 2'h0, q);
    end
    wr(LFOSC_CTRL_OFS, 32'h0);
    rd(LFOSC_CTRL_OFS, 32'h0, 32'h80, 2'h0, q);
    $display("test divider done");
    // Each mode sets the pin claims and reads back with a random range
    for (int m = 0; m < 8; m++) begin
      seed = lfsr(seed);
      e = {25'h0, m[2:0], 1'b0, seed[2:0]};
      wr(LFOSC_EXT_OFS, e);
      chk("pin in", 32'(o_crystal_in_pin_en), 32'(m >= 6));
      chk("pin out", 32'(o_crystal_out_pin_en), 32'(m >= 2));
      rd(LFOSC_EXT_OFS, e, 32'h7F, 2'h0, q);
    end
    repeat (XS + 8) @(posedge i_ref_clk);
    rd(LFOSC_EXT_OFS, e | 32'h80, 32'hFF, 2'h0, q);
    $display("test pins done");
    stop_test();
  end
endmodule : lfosc_top_bench
